// ### usb_host_mode_control_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "mode_ctrl_map.vh"

module usb_host_mode_control_regs #(
   parameter SOF_DELAY = `SOF_DELAY_CYCLES
) (
   input  wire        clk,
   input  wire        srst,
   // register port
   input  wire        reg_sel,
   input  wire        reg_wr,
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   output reg  [31:0] reg_rdata_q,
   // soft reset command and root hub
   input  wire        soft_reset,
   input  wire        downstream_resume,
   output reg         root_hub_reset_q,
   // interrupt inputs from status logic
   input  wire        resume_detected,
   input  wire        status_irq,
   output reg         host_irq_q,
   output reg         smi_irq_q,
   output reg         remote_wake_q,
   // frame timing
   input  wire        frame_start,
   input  wire        bulk_pass_req,
   output reg         frame_token_started_q,
   output reg         sof_running_q,
   output reg         bulk_go_q,
   output reg         control_list_on_q,
   output reg         periodic_list_on_q,
   output reg         isochronous_on_q,
   output reg  [1:0]  ctrl_bulk_ratio_q
);

   // stored control fields and their next values
   reg        remote_wake_permit_q;
   reg        remote_wake_permit_d;
   reg        remote_wake_wired_q;
   reg        remote_wake_wired_d;
   reg        interrupt_routing_q;
   reg        interrupt_routing_d;
   reg  [1:0] functional_state_q;
   reg  [1:0] functional_state_d;
   reg        bulk_list_on_q;
   reg        bulk_list_on_d;
   reg        control_list_on_d;
   reg        periodic_list_on_d;
   reg        isochronous_on_d;
   reg  [1:0] ctrl_bulk_ratio_d;
   reg [31:0] reg_rdata_d;
   reg        bulk_frame_q;
   reg [16:0] sof_cnt_q;
   reg        sof_wait_q;

   localparam [31:0] SOF_LAST_W = SOF_DELAY - 1;
   wire        ctrl_wr = reg_sel & reg_wr & (reg_addr == `OFS_OP_MODE_CTRL);
   wire  [1:0] wr_state = reg_wdata[`FLD_FSTATE_LSB +: 2];
   wire [16:0] sof_last = SOF_LAST_W[16:0];
   wire        sof_done = sof_wait_q & (sof_cnt_q == sof_last);
   wire        op_now = (functional_state_q == `FS_STATE_OPERATIONAL);
   wire        op_next = (functional_state_d == `FS_STATE_OPERATIONAL);
   wire        sof_fire = sof_done & op_now & op_next;
   wire [31:0] revision_word = {24'h000000, `SPEC_VERSION_BCD};
   // bits 31:11 are not stored, so they read as zero
   wire [31:0] control_word = {21'h000000, remote_wake_permit_q, remote_wake_wired_q,
                               interrupt_routing_q, functional_state_q, bulk_list_on_q,
                               control_list_on_q, isochronous_on_q, periodic_list_on_q,
                               ctrl_bulk_ratio_q};

   // cleared by either reset; a write in the soft reset cycle is dropped
   always @* begin
      remote_wake_permit_d = remote_wake_permit_q;
      if (soft_reset) begin
         remote_wake_permit_d = `RST_BIT;
      end else if (ctrl_wr) begin
         remote_wake_permit_d = reg_wdata[`FLD_PERMIT_BIT];
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         remote_wake_permit_q <= `RST_BIT;
      end else begin
         remote_wake_permit_q <= remote_wake_permit_d;
      end
   end

   always @* begin
      bulk_list_on_d = bulk_list_on_q;
      if (soft_reset) begin
         bulk_list_on_d = `RST_BIT;
      end else if (ctrl_wr) begin
         bulk_list_on_d = reg_wdata[`FLD_BULK_BIT];
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         bulk_list_on_q <= `RST_BIT;
      end else begin
         bulk_list_on_q <= bulk_list_on_d;
      end
   end

   always @* begin
      control_list_on_d = control_list_on_q;
      if (soft_reset) begin
         control_list_on_d = `RST_BIT;
      end else if (ctrl_wr) begin
         control_list_on_d = reg_wdata[`FLD_CTRL_LIST_BIT];
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         control_list_on_q <= `RST_BIT;
      end else begin
         control_list_on_q <= control_list_on_d;
      end
   end

   always @* begin
      periodic_list_on_d = periodic_list_on_q;
      if (soft_reset) begin
         periodic_list_on_d = `RST_BIT;
      end else if (ctrl_wr) begin
         periodic_list_on_d = reg_wdata[`FLD_PERIODIC_BIT];
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         periodic_list_on_q <= `RST_BIT;
      end else begin
         periodic_list_on_q <= periodic_list_on_d;
      end
   end

   always @* begin
      isochronous_on_d = isochronous_on_q;
      if (soft_reset) begin
         isochronous_on_d = `RST_BIT;
      end else if (ctrl_wr) begin
         isochronous_on_d = reg_wdata[`FLD_ISO_BIT];
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         isochronous_on_q <= `RST_BIT;
      end else begin
         isochronous_on_q <= isochronous_on_d;
      end
   end

   always @* begin
      ctrl_bulk_ratio_d = ctrl_bulk_ratio_q;
      if (soft_reset) begin
         ctrl_bulk_ratio_d = `RST_RATIO;
      end else if (ctrl_wr) begin
         ctrl_bulk_ratio_d = reg_wdata[`FLD_RATIO_LSB +: 2];
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         ctrl_bulk_ratio_q <= `RST_RATIO;
      end else begin
         ctrl_bulk_ratio_q <= ctrl_bulk_ratio_d;
      end
   end

   // wired and routing survive a soft reset, only srst clears them
   always @* begin
      remote_wake_wired_d = remote_wake_wired_q;
      if (ctrl_wr && !soft_reset) begin
         remote_wake_wired_d = reg_wdata[`FLD_WIRED_BIT];
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         remote_wake_wired_q <= `RST_BIT;
      end else begin
         remote_wake_wired_q <= remote_wake_wired_d;
      end
   end

   always @* begin
      interrupt_routing_d = interrupt_routing_q;
      if (ctrl_wr && !soft_reset) begin
         interrupt_routing_d = reg_wdata[`FLD_ROUTING_BIT];
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         interrupt_routing_q <= `RST_BIT;
      end else begin
         interrupt_routing_q <= interrupt_routing_d;
      end
   end

   // soft reset wins over a driver write, which wins over hardware; hardware only steps suspend to resume
   always @* begin
      functional_state_d = functional_state_q;
      if (soft_reset) begin
         functional_state_d = `FS_STATE_SUSPEND;
      end else if (ctrl_wr) begin
         functional_state_d = wr_state;
      end else if (functional_state_q == `FS_STATE_SUSPEND && downstream_resume) begin
         functional_state_d = `FS_STATE_RESUME;
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         functional_state_q <= `FS_STATE_RESET;
      end else begin
         functional_state_q <= functional_state_d;
      end
   end

   // root hub held in reset for the whole hardware reset, then one cycle more
   always @(posedge clk) begin
      if (srst) begin
         root_hub_reset_q <= `RST_HUB_HELD;
      end else begin
         root_hub_reset_q <= `RST_BIT;
      end
   end

   // delay restarts only on entry to operational; writes that keep it do not
   always @(posedge clk) begin
      if (srst) begin
         sof_wait_q <= `RST_BIT;
      end else if (!op_next) begin
         sof_wait_q <= `RST_BIT;
      end else if (!op_now) begin
         sof_wait_q <= 1'h1;
      end else if (sof_done) begin
         sof_wait_q <= `RST_BIT;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         sof_cnt_q <= `RST_SOF_CNT;
      end else if (!op_now) begin
         sof_cnt_q <= `RST_SOF_CNT;
      end else if (sof_wait_q && !sof_done) begin
         sof_cnt_q <= sof_cnt_q + 17'h00001;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         sof_running_q <= `RST_BIT;
      end else if (!op_next) begin
         sof_running_q <= `RST_BIT;
      end else if (sof_fire) begin
         sof_running_q <= 1'h1;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         frame_token_started_q <= `RST_BIT;
      end else begin
         frame_token_started_q <= sof_fire;
      end
   end

   // bulk enable latched at frame start, sampled again at each pass
   always @(posedge clk) begin
      if (srst || soft_reset) begin
         bulk_frame_q <= `RST_BIT;
      end else if (frame_start) begin
         bulk_frame_q <= bulk_list_on_q;
      end
   end

   always @(posedge clk) begin
      if (srst || soft_reset) begin
         bulk_go_q <= `RST_BIT;
      end else begin
         bulk_go_q <= bulk_pass_req & bulk_frame_q & bulk_list_on_q;
      end
   end

   // interrupt and wake outputs
   always @(posedge clk) begin
      if (srst) begin
         host_irq_q <= `RST_BIT;
      end else begin
         host_irq_q <= status_irq & ~interrupt_routing_q;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         smi_irq_q <= `RST_BIT;
      end else begin
         smi_irq_q <= status_irq & interrupt_routing_q;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         remote_wake_q <= `RST_BIT;
      end else begin
         remote_wake_q <= remote_wake_permit_q & resume_detected;
      end
   end

   // register read; data holds until the next read
   always @* begin
      reg_rdata_d = reg_rdata_q;
      if (reg_sel && !reg_wr) begin
         case (reg_addr)
            `OFS_SPEC_REVISION: begin
               reg_rdata_d = revision_word;
            end
            `OFS_OP_MODE_CTRL: begin
               reg_rdata_d = control_word;
            end
            default: begin
               reg_rdata_d = `RST_RDATA;
            end
         endcase
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         reg_rdata_q <= `RST_RDATA;
      end else begin
         reg_rdata_q <= reg_rdata_d;
      end
   end

endmodule // usb_host_mode_control_regs
`default_nettype wire

// ### mode_ctrl_map.vh
`ifndef MODE_CTRL_MAP_VH
`define MODE_CTRL_MAP_VH
`define OFS_SPEC_REVISION    8'h00
`define OFS_OP_MODE_CTRL     8'h04
`define SPEC_VERSION_BCD     8'h10
`define CTRL_RESET_VALUE     32'h0000_0000
`define RST_BIT              1'h0
`define RST_RATIO            2'h0
`define RST_HUB_HELD         1'h1
`define RST_RDATA            32'h0000_0000
`define RST_SOF_CNT          17'h00000
`define FLD_RATIO_LSB        0
`define FLD_PERIODIC_BIT     2
`define FLD_ISO_BIT          3
`define FLD_CTRL_LIST_BIT    4
`define FLD_BULK_BIT         5
`define FLD_FSTATE_LSB       6
`define FLD_ROUTING_BIT      8
`define FLD_WIRED_BIT        9
`define FLD_PERMIT_BIT       10
`define FS_STATE_RESET       2'h0
`define FS_STATE_RESUME      2'h1
`define FS_STATE_OPERATIONAL 2'h2
`define FS_STATE_SUSPEND     2'h3
`define SOF_DELAY_NS         1000000
`define CLK_PERIOD_NS        10
`define SOF_DELAY_CYCLES     (`SOF_DELAY_NS / `CLK_PERIOD_NS)
`endif

// ### mode_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mode_ctrl_monitor #(
   parameter int SOF_DELAY = 20
) (
   // clock, reset and register port
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        reg_sel,
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata_q,
   // status and frame inputs
   input wire logic        status_irq,
   input wire logic        resume_detected,
   input wire logic        bulk_pass_req,
   // watched outputs
   input wire logic        root_hub_reset_q,
   input wire logic        host_irq_q,
   input wire logic        smi_irq_q,
   input wire logic        remote_wake_q,
   input wire logic        frame_token_started_q,
   input wire logic        sof_running_q,
   input wire logic        bulk_go_q
);
   localparam int D = SOF_DELAY + 1;
   wire ctl_wr = reg_sel && reg_wr && reg_addr == 8'h04;
   wire rd_op  = reg_sel && !reg_wr;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_enter_op;
      ctl_wr && reg_wdata[7:6] == 2'h2 && !sof_running_q;
   endsequence
   sequence s_token_due;
      ##D frame_token_started_q && sof_running_q;
   endsequence
   a_sof_delay: assert property (s_enter_op |-> s_token_due)
      else $error("frame tokens not on time");
   a_sof_flag: assert property ($rose(sof_running_q) |-> frame_token_started_q)
      else $error("token flag missing");
   a_sof_stop: assert property (ctl_wr && reg_wdata[7:6] != 2'h2 |=> !sof_running_q)
      else $error("frame tokens kept running");
   a_rev_read: assert property (rd_op && reg_addr == 8'h00 |=> reg_rdata_q == 32'h10)
      else $error("revision value wrong");
   a_unmapped_zero: assert property (rd_op && reg_addr[7:3] != 5'h0 |=> reg_rdata_q == 32'h0)
      else $error("unmapped read not zero");
   a_irq_route: assert property (!$past(srst) |-> (host_irq_q | smi_irq_q) == $past(status_irq))
      else $error("interrupt lost or invented");
   a_wake_cause: assert property (remote_wake_q |-> $past(resume_detected))
      else $error("wake without resume");
   a_bulk_cause: assert property (bulk_go_q |-> $past(bulk_pass_req))
      else $error("bulk pass without request");
   a_hub_reset: assert property ($fell(srst) |-> root_hub_reset_q)
      else $error("root hub reset missing");
endmodule // mode_ctrl_monitor
bind usb_host_mode_control_regs mode_ctrl_monitor #(.SOF_DELAY(SOF_DELAY)) u_mon (
   .clk(clk), .srst(srst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .status_irq(status_irq),
   .resume_detected(resume_detected), .bulk_pass_req(bulk_pass_req),
   .root_hub_reset_q(root_hub_reset_q), .host_irq_q(host_irq_q), .smi_irq_q(smi_irq_q),
   .remote_wake_q(remote_wake_q), .frame_token_started_q(frame_token_started_q),
   .sof_running_q(sof_running_q), .bulk_go_q(bulk_go_q));
`default_nettype wire

// ### usb_host_mode_control_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module usb_host_mode_control_regs_test;
   localparam int DLY = 20;
   logic        clk = 0, srst = 1, reg_sel = 0, reg_wr = 0, soft_reset = 0;
   logic        downstream_resume = 0, resume_detected = 0, status_irq = 0;
   logic        frame_start = 0, bulk_pass_req = 0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata_q;
   logic        root_hub_reset_q, host_irq_q, smi_irq_q, remote_wake_q, frame_token_started_q;
   logic        sof_running_q, bulk_go_q, control_list_on_q, periodic_list_on_q, isochronous_on_q;
   logic [1:0]  ctrl_bulk_ratio_q;
   int          fail_count = 0, cmp_count = 0, n;
   always #5 clk = ~clk;
   usb_host_mode_control_regs #(.SOF_DELAY(DLY)) i_dut (
      .clk(clk), .srst(srst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .soft_reset(soft_reset),
      .downstream_resume(downstream_resume), .root_hub_reset_q(root_hub_reset_q),
      .resume_detected(resume_detected), .status_irq(status_irq), .host_irq_q(host_irq_q),
      .smi_irq_q(smi_irq_q), .remote_wake_q(remote_wake_q), .frame_start(frame_start),
      .bulk_pass_req(bulk_pass_req), .frame_token_started_q(frame_token_started_q),
      .sof_running_q(sof_running_q), .bulk_go_q(bulk_go_q),
      .control_list_on_q(control_list_on_q), .periodic_list_on_q(periodic_list_on_q),
      .isochronous_on_q(isochronous_on_q), .ctrl_bulk_ratio_q(ctrl_bulk_ratio_q));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_sel <= 1'h1;
      reg_wr <= w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_sel <= 1'h0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      acc(1'h0, a, 32'h0);
      #1;
      chk(reg_rdata_q, e);
   endtask
   task tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task results;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'h0;
      rd(8'h00, 32'h10);
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h0);
      $display("test reset done");
      acc(1'h1, 8'h04, 32'hffff_ffff);
      rd(8'h04, 32'h7ff);
      chk({ctrl_bulk_ratio_q, control_list_on_q, periodic_list_on_q, isochronous_on_q}, 5'h1f);
      acc(1'h1, 8'h00, 32'h0);
      rd(8'h00, 32'h10);
      @(posedge clk);
      soft_reset <= 1'h1;
      @(posedge clk);
      soft_reset <= 1'h0;
      rd(8'h04, 32'h3c0);
      @(posedge clk);
      srst <= 1'h1;
      tick(1);
      chk(root_hub_reset_q, 1'h1);
      @(posedge clk);
      srst <= 1'h0;
      rd(8'h04, 32'h0);
      chk(root_hub_reset_q, 1'h0);
      $display("test resets done");
      @(posedge clk);
      status_irq <= 1'h1;
      resume_detected <= 1'h1;
      tick(2);
      chk({host_irq_q, smi_irq_q, remote_wake_q}, 3'h4);
      acc(1'h1, 8'h04, 32'h500);
      tick(2);
      chk({host_irq_q, smi_irq_q, remote_wake_q}, 3'h3);
      @(posedge clk);
      status_irq <= 1'h0;
      resume_detected <= 1'h0;
      acc(1'h1, 8'h04, 32'hc0);
      downstream_resume <= 1'h1;
      tick(2);
      rd(8'h04, 32'h40);
      acc(1'h1, 8'h04, 32'h0);
      tick(2);
      rd(8'h04, 32'h0);
      downstream_resume <= 1'h0;
      $display("test routing and state done");
      acc(1'h1, 8'h04, 32'ha0);
      for (n = 1; n < 100; n++) begin
         @(posedge clk);
         #1;
         if (frame_token_started_q === 1'h1) break;
      end
      chk(n, DLY);
      if (n == 100) fail_count++;
      chk(sof_running_q, 1'h1);
      @(posedge clk);
      frame_start <= 1'h1;
      @(posedge clk);
      frame_start <= 1'h0;
      bulk_pass_req <= 1'h1;
      tick(1);
      chk(bulk_go_q, 1'h1);
      bulk_pass_req <= 1'h0;
      acc(1'h1, 8'h04, 32'h80);
      bulk_pass_req <= 1'h1;
      tick(1);
      chk(bulk_go_q, 1'h0);
      bulk_pass_req <= 1'h0;
      acc(1'h1, 8'h04, 32'h0);
      tick(1);
      chk(sof_running_q, 1'h0);
      $display("test frame and bulk done");
      results;
   end
endmodule // usb_host_mode_control_regs_test
`default_nettype wire
